/* hdl/vss_dev.sv */
// How it works
// R1 - Source sends frame start with both markers
// R2 - Input data counts only while valid high
// R3 - Ready low stalls; source holds pixel pending
// R4 - Output uses same valid-ready stream protocol
// R5 - Output line start marked with first pixel
// R6 - Sink ignores output bus while valid low
// R7 - Transfer only when valid and ready high
// R8 - Keep scale parameters constant where possible
// R9 - Transfers happen on rising edge, both high
// R10 - Later lines carry line start marker only
// R11 - Restart scaler after any parameter change
// R12 - After reset, wait for frame start
// R13 - Reset clears pipeline, output valid low
`timescale 1ns/1ps
`default_nettype none
`include "vss_consts.svh"
module vss_dev
   import vss_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   vss_link_if.dev link,
   output logic locked,
   output logic sync_err,
   output vss_cnt_t line_count,
   output vss_cnt_t frame_count
);
   // Pipeline state; pixels pass unchanged, the scale datapath is not here
   vss_lock_e lstate;
   vss_lock_e next_lstate;
   vss_beat_s in_beat;
   vss_beat_s skid;
   vss_beat_s next_out;
   logic skid_val;

   // Frame head needs both markers in the same beat
   function automatic logic is_frame_head(input vss_beat_s beat);
      return beat.vsync & beat.hsync;
   endfunction

   // Frame mark without line mark breaks the pairing
   function automatic logic is_bad_head(input vss_beat_s beat);
      return beat.vsync & ~beat.hsync;
   endfunction

   // Status counters wrap past the top; nothing steers flow by them
   function automatic vss_cnt_t bump(input vss_cnt_t cnt);
      return cnt + `VSS_CNT_ONE;
   endfunction

   // Restart from the host acts like the system reset;
   // beats in flight at that moment are lost on purpose
   wire logic run_n = rst_n & link.restart_n; // R11 R13

   // Input beat as it stands on the link
   assign in_beat.pix = link.pixin;
   assign in_beat.vsync = link.pixin_vsync;
   assign in_beat.hsync = link.pixin_hsync;

   // Handshake and frame lock decode
   wire logic in_fire = link.pixin_val & link.pixin_rdy; // R2 R7 R9
   wire logic frame_head = is_frame_head(in_beat);
   wire logic lock_hit = in_fire & frame_head; // R1 R12
   wire logic in_keep = in_fire & ((lstate == VSS_RUN) | frame_head); // R12
   wire logic out_free = ~link.pixout_val | link.pixout_rdy; // R4 R7 R9
   wire logic out_fire = link.pixout_val & link.pixout_rdy;
   wire logic bad_head = in_fire & is_bad_head(in_beat);

   // Shovel selection: a parked beat always leaves before a new one,
   // so beat order is kept through a stall
   wire logic next_out_val = skid_val | in_keep; // R4
   wire logic out_load = out_free & next_out_val;
   wire logic skid_load = ~out_free & in_keep;
   wire logic next_skid_val = out_free ? 1'b0 : (skid_val | in_keep);
   assign next_out = skid_val ? skid : in_beat; // R2

   // Ready is registered, so one beat may still land in the skid
   // the cycle the output stalls; ready drops as the skid fills
   wire logic next_in_rdy = ~next_skid_val; // R3

   // Output valid stands until the sink takes the beat
   always_ff @(posedge clock) begin
      if (!run_n) begin
         link.pixout_val <= 1'b0; // R13
      end else if (out_free) begin
         link.pixout_val <= next_out_val; // R4
      end
   end

   // Pixel word of the output beat
   always_ff @(posedge clock) begin
      if (!run_n) begin
         link.pixout <= `VSS_PIX_RST;
      end else if (out_load) begin
         link.pixout <= next_out.pix; // R2
      end
   end

   // Markers travel with their pixel, never on their own
   always_ff @(posedge clock) begin
      if (!run_n) begin
         link.pixout_vsync <= 1'b0;
         link.pixout_hsync <= 1'b0;
      end else if (out_load) begin
         link.pixout_vsync <= next_out.vsync;
         link.pixout_hsync <= next_out.hsync; // R5
      end
   end

   // Skid holds the one beat that was in flight at a stall
   always_ff @(posedge clock) begin
      if (!run_n) begin
         skid <= '0;
      end else if (skid_load) begin
         skid <= in_beat;
      end
   end

   // Skid fill flag
   always_ff @(posedge clock) begin
      if (!run_n) begin
         skid_val <= 1'b0;
      end else begin
         skid_val <= next_skid_val;
      end
   end

   // Input ready, low through reset so nothing is taken early
   always_ff @(posedge clock) begin
      if (!run_n) begin
         link.pixin_rdy <= 1'b0;
      end else begin
         link.pixin_rdy <= next_in_rdy; // R3
      end
   end

   // Next lock state; only a full frame head ends the wait
   always_comb begin
      next_lstate = lstate;
      case (lstate)
         VSS_WAIT_FRAME: begin
            if (lock_hit) begin // R1 R12
               next_lstate = VSS_RUN;
            end
         end
         VSS_RUN: begin
            next_lstate = VSS_RUN;
         end
         default: begin
            next_lstate = VSS_WAIT_FRAME;
         end
      endcase
   end

   // Lock state; a restart drops it until the next frame head,
   // so a half frame never reaches the output
   always_ff @(posedge clock) begin
      if (!run_n) begin
         lstate <= VSS_WAIT_FRAME; // R12
      end else begin
         lstate <= next_lstate;
      end
   end

   // Lock flag follows the state it is about to enter
   always_ff @(posedge clock) begin
      if (!run_n) begin
         locked <= 1'b0;
      end else begin
         locked <= (next_lstate == VSS_RUN);
      end
   end

   // Sticky marker error, cleared only by reset or restart
   always_ff @(posedge clock) begin
      if (!run_n) begin
         sync_err <= 1'b0;
      end else if (bad_head) begin // R1 R10
         sync_err <= 1'b1;
      end
   end

   // Output line and frame ticks, taken as beats leave
   wire logic frame_tick = out_fire & link.pixout_vsync;
   wire logic line_tick = out_fire & ~link.pixout_vsync & link.pixout_hsync; // R5

   // Frames delivered since reset or restart
   always_ff @(posedge clock) begin
      if (!run_n) begin
         frame_count <= `VSS_CNT_RST;
      end else if (frame_tick) begin
         frame_count <= bump(frame_count);
      end
   end

   // Line number within the current output frame, first line is one
   always_ff @(posedge clock) begin
      if (!run_n) begin
         line_count <= `VSS_CNT_RST;
      end else if (frame_tick) begin
         line_count <= `VSS_CNT_ONE;
      end else if (line_tick) begin
         line_count <= bump(line_count);
      end
   end
endmodule
`default_nettype wire

/* hdl/vss_consts.svh */
`ifndef VSS_CONSTS_SVH
`define VSS_CONSTS_SVH

// Pixel and counter widths
`define VSS_PIX_W 24
`define VSS_CNT_W 16

// Restart pulse after a parameter change, in ns and in 25 ns cycles
`define VSS_CLK_NS 25
`define VSS_RESTART_NS 25
`define VSS_RESTART_CYC (((`VSS_RESTART_NS) + (`VSS_CLK_NS) - 1) / (`VSS_CLK_NS))

// Reset values
`define VSS_PIX_RST 24'h000000
`define VSS_CNT_RST 16'h0000
`define VSS_CNT_ONE 16'h0001

`endif

/* hdl/vss_pkg.sv */
package vss_pkg;
   `include "vss_consts.svh"

   typedef logic [`VSS_PIX_W-1:0] vss_pix_t;
   typedef logic [`VSS_CNT_W-1:0] vss_cnt_t;

   // One beat of the stream: pixel plus its two markers
   typedef struct packed {
      vss_pix_t pix;
      logic vsync;
      logic hsync;
   } vss_beat_s;

   // Device lock state after reset
   typedef enum logic {
      VSS_WAIT_FRAME,
      VSS_RUN
   } vss_lock_e;

   // Host restart sequencer
   typedef enum logic {
      VSS_HOST_IDLE,
      VSS_HOST_RESTART
   } vss_host_e;
endpackage

/* hdl/vss_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vss_link_if;
   import vss_pkg::*;
   // Input side, source to scaler
   vss_pix_t pixin;
   logic pixin_vsync;
   logic pixin_hsync;
   logic pixin_val;
   logic pixin_rdy;
   // Output side, scaler to sink
   vss_pix_t pixout;
   logic pixout_vsync;
   logic pixout_hsync;
   logic pixout_val;
   logic pixout_rdy;
   // Restart request after a parameter change, active low
   logic restart_n;

   modport dev (
      input pixin, pixin_vsync, pixin_hsync, pixin_val, pixout_rdy, restart_n,
      output pixin_rdy, pixout, pixout_vsync, pixout_hsync, pixout_val
   );
   modport host (
      output pixin, pixin_vsync, pixin_hsync, pixin_val, pixout_rdy, restart_n,
      input pixin_rdy, pixout, pixout_vsync, pixout_hsync, pixout_val
   );
endinterface
`default_nettype wire

/* hdl/vss_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vss_consts.svh"
module vss_host
   import vss_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   vss_link_if.host link,
   // Pixels offered by the user to the scaler
   input wire vss_pix_t src_pix,
   input wire logic src_frame_start,
   input wire logic src_line_start,
   input wire logic src_val,
   output logic src_rdy,
   // Pixels handed from the scaler to the user
   output vss_pix_t snk_pix,
   output logic snk_vsync,
   output logic snk_hsync,
   output logic snk_val,
   input wire logic snk_rdy,
   // Parameters changed: pulse the scaler restart
   input wire logic param_change
);
   vss_beat_s src_beat, src_skid, snk_skid;
   logic src_skid_val, snk_skid_val;
   logic [7:0] rst_cnt;
   vss_host_e hstate;

   // Frame start carries both markers, line start only hsync
   assign src_beat.pix = src_pix;
   assign src_beat.vsync = src_frame_start; // R1 R10
   assign src_beat.hsync = src_frame_start | src_line_start; // R1 R10

   wire logic src_take = src_val & src_rdy;
   wire logic src_free = ~link.pixin_val | link.pixin_rdy; // R3 R7 R9
   wire logic snk_take = link.pixout_val & link.pixout_rdy; // R6 R7 R9
   wire logic snk_free = ~snk_val | snk_rdy;
   wire logic next_src_skid_val = src_free ? 1'b0 : (src_skid_val | src_take);
   wire logic next_snk_skid_val = snk_free ? 1'b0 : (snk_skid_val | snk_take);

   // Source side: current pixel stays pending until the scaler takes it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         link.pixin_val <= 1'b0;
         link.pixin <= `VSS_PIX_RST;
         link.pixin_vsync <= 1'b0;
         link.pixin_hsync <= 1'b0;
         src_skid <= '0;
         src_skid_val <= 1'b0;
         src_rdy <= 1'b0;
      end else begin
         if (src_free) begin // R3
            link.pixin_val <= src_skid_val | src_take;
            if (src_skid_val) begin
               {link.pixin, link.pixin_vsync, link.pixin_hsync} <= src_skid;
            end else if (src_take) begin
               {link.pixin, link.pixin_vsync, link.pixin_hsync} <= src_beat;
            end
         end else if (src_take) begin
            src_skid <= src_beat;
         end
         src_skid_val <= next_src_skid_val;
         src_rdy <= ~next_src_skid_val;
      end
   end

   // Sink side: capture only beats marked valid
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         snk_val <= 1'b0;
         snk_pix <= `VSS_PIX_RST;
         snk_vsync <= 1'b0;
         snk_hsync <= 1'b0;
         snk_skid <= '0;
         snk_skid_val <= 1'b0;
         link.pixout_rdy <= 1'b0;
      end else begin
         if (snk_free) begin
            snk_val <= snk_skid_val | snk_take;
            if (snk_skid_val) begin
               {snk_pix, snk_vsync, snk_hsync} <= snk_skid;
            end else if (snk_take) begin // R6
               {snk_pix, snk_vsync, snk_hsync} <= {link.pixout, link.pixout_vsync, link.pixout_hsync};
            end
         end else if (snk_take) begin
            snk_skid <= {link.pixout, link.pixout_vsync, link.pixout_hsync};
         end
         snk_skid_val <= next_snk_skid_val;
         link.pixout_rdy <= ~next_snk_skid_val;
      end
   end

   // Restart pulse of at least one cycle after new parameters
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hstate <= VSS_HOST_IDLE;
         rst_cnt <= 8'h00;
         link.restart_n <= 1'b1;
      end else begin
         case (hstate)
            VSS_HOST_IDLE: begin
               if (param_change) begin // R11
                  hstate <= VSS_HOST_RESTART;
                  rst_cnt <= 8'((`VSS_RESTART_CYC) - 1);
                  link.restart_n <= 1'b0;
               end
            end
            VSS_HOST_RESTART: begin
               if (rst_cnt == 8'h00) begin
                  hstate <= VSS_HOST_IDLE;
                  link.restart_n <= 1'b1;
               end else begin
                  rst_cnt <= rst_cnt - 8'h01;
               end
            end
            default: begin
               hstate <= VSS_HOST_IDLE;
               link.restart_n <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* verif/vss_props.sv */
`timescale 1ns/1ps
`default_nettype none
module vss_props
   import vss_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pixin_vsync,
   input wire logic pixin_hsync,
   input wire logic pixin_val,
   input wire logic pixin_rdy,
   input wire vss_pix_t pixout,
   input wire logic pixout_vsync,
   input wire logic pixout_hsync,
   input wire logic pixout_val,
   input wire logic pixout_rdy,
   input wire logic restart_n
);
   logic seen;
   wire sync_take = pixin_val && pixin_rdy && pixin_vsync && pixin_hsync;

   // Lock must be earned again after either reset
   always_ff @(posedge clock) begin
      if (!rst_n || !restart_n) begin
         seen <= 1'b0;
      end else if (sync_take) begin
         seen <= 1'b1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_stall_hold: assert property (pixout_val && !pixout_rdy && restart_n |=>
      pixout_val && $stable({pixout, pixout_vsync, pixout_hsync})) else $error("output moved while stalled");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n || !restart_n |=>
      !pixout_val && !pixin_rdy) else $error("valid or ready high after reset");
   a_rise_cause: assert property ($rose(pixout_val) |->
      $past(pixin_val && pixin_rdy)) else $error("output valid without an input transfer");
   a_lock_first: assert property (pixout_val |-> seen) else $error("output before frame start");
   a_first_sync: assert property ($rose(seen) |->
      pixout_val && pixout_vsync && pixout_hsync) else $error("first beat lacks markers");
   a_rdy_falls: assert property (pixout_val && !pixout_rdy && pixin_val && pixin_rdy && restart_n |=>
      !pixin_rdy) else $error("ready stays high through stall");
   a_rdy_back: assert property ((pixout_rdy && restart_n)[*3] |-> pixin_rdy) else $error("ready stuck low");
   a_line_mark: assert property (pixout_val && pixout_vsync |-> pixout_hsync) else $error("frame mark alone");
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("BAD %s exp %0h got %0h", n, e, g); \
   end \
end
module testbench;
   import vss_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   vss_pix_t src_pix = 24'h000000;
   logic src_frame_start = 1'b0;
   logic src_line_start = 1'b0;
   logic src_val = 1'b0;
   logic snk_rdy = 1'b0;
   logic param_change = 1'b0;
   logic src_rdy, snk_vsync, snk_hsync, snk_val, locked, sync_err;
   vss_pix_t snk_pix;
   vss_cnt_t line_count, frame_count;
   int errors = 0;
   int comparisons = 0;
   logic [25:0] exp_q[$];
   logic [25:0] got_e;
   logic lk = 1'b0;

   // 40 MHz
   always #12.5 clock = ~clock;

   vss_link_if link();
   vss_host vss_host_i(.clock(clock), .rst_n(rst_n), .link(link), .src_pix(src_pix),
      .src_frame_start(src_frame_start), .src_line_start(src_line_start), .src_val(src_val),
      .src_rdy(src_rdy), .snk_pix(snk_pix), .snk_vsync(snk_vsync), .snk_hsync(snk_hsync),
      .snk_val(snk_val), .snk_rdy(snk_rdy), .param_change(param_change));
   vss_dev vss_dev_i(.clock(clock), .rst_n(rst_n), .link(link), .locked(locked),
      .sync_err(sync_err), .line_count(line_count), .frame_count(frame_count));
   vss_props vss_props_i(.clock(clock), .rst_n(rst_n), .pixin_vsync(link.pixin_vsync),
      .pixin_hsync(link.pixin_hsync), .pixin_val(link.pixin_val), .pixin_rdy(link.pixin_rdy),
      .pixout(link.pixout), .pixout_vsync(link.pixout_vsync), .pixout_hsync(link.pixout_hsync),
      .pixout_val(link.pixout_val), .pixout_rdy(link.pixout_rdy), .restart_n(link.restart_n));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Every delivered beat must be the next expected one, in order
   always @(posedge clock) begin
      if (snk_val === 1'b1 && snk_rdy === 1'b1) begin
         got_e = exp_q.size() > 0 ? exp_q.pop_front() : 26'h3FFFFFF;
         `CHK("beat", got_e, {snk_pix, snk_vsync, snk_hsync})
      end
   end

   // Holds the beat until ready was high at the edge; pre-lock beats expect nothing
   task automatic send(input vss_pix_t p, input logic fs, input logic ls);
      src_pix <= p;
      src_frame_start <= fs;
      src_line_start <= ls;
      src_val <= 1'b1;
      if (fs) lk = 1'b1;
      if (lk) exp_q.push_back({p, fs, fs | ls});
      do @(posedge clock); while (src_rdy !== 1'b1);
   endtask

   task automatic frame(input int lines, input int ppl, input vss_pix_t base);
      for (int l = 0; l < lines; l++) begin
         for (int p = 0; p < ppl; p++) begin
            send(base + vss_pix_t'(l * 16 + p), l == 0 && p == 0, p == 0);
         end
      end
      src_val <= 1'b0;
   endtask

   task automatic drain(input int lc, input int fc);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 300) begin
         @(posedge clock);
         n++;
      end
      repeat (4) @(posedge clock);
      `CHK("left", 0, exp_q.size())
      `CHK("lines", vss_cnt_t'(lc), line_count)
      `CHK("frames", vss_cnt_t'(fc), frame_count)
      `CHK("sync_err", 1'b0, sync_err)
   endtask

   task automatic t_lock();
      send(24'h0000A1, 1'b0, 1'b1);
      send(24'h0000A2, 1'b0, 1'b0);
      frame(2, 3, 24'h100000);
      drain(2, 1);
      `CHK("locked", 1'b1, locked)
      $display("test lock done");
   endtask

   // Sink stalls long enough to fill every stage
   task automatic t_stall();
      snk_rdy <= 1'b0;
      fork
         frame(3, 4, 24'h200000);
         begin
            repeat (30) @(posedge clock);
            `CHK("src_rdy", 1'b0, src_rdy)
            snk_rdy <= 1'b1;
         end
      join
      drain(3, 2);
      $display("test stall done");
   endtask

   task automatic t_restart();
      param_change <= 1'b1;
      @(posedge clock);
      param_change <= 1'b0;
      lk = 1'b0;
      repeat (4) @(posedge clock);
      `CHK("locked", 1'b0, locked)
      `CHK("frames", 16'h0000, frame_count)
      send(24'h0000B1, 1'b0, 1'b1);
      frame(1, 5, 24'h300000);
      drain(1, 1);
      $display("test restart done");
   endtask

   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      snk_rdy <= 1'b1;
      repeat (3) @(posedge clock);
      t_lock();
      t_stall();
      t_restart();
      print_verdict();
   end

   // Tests need about a hundred cycles; allow eighty times that
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
